// ===== core/rpu_cfg.svh
// Constants for the region protection unit: selectors, fields, resets, codes
`ifndef RPU_CFG_SVH
`define RPU_CFG_SVH

// Coprocessor register selectors
`define RPU_SEL_CTRL      4'h0
`define RPU_SEL_DCACHE    4'h1
`define RPU_SEL_ICACHE    4'h2
`define RPU_SEL_BUFFER    4'h3
`define RPU_SEL_DAP_STD   4'h4
`define RPU_SEL_IAP_STD   4'h5
`define RPU_SEL_DAP_EXT   4'h6
`define RPU_SEL_IAP_EXT   4'h7
`define RPU_SEL_DFSR      4'h8
`define RPU_SEL_IFSR      4'h9
`define RPU_SEL_DFAR      4'ha
`define RPU_SEL_IFAR      4'hb
`define RPU_SEL_REGION    4'hc
`define RPU_SEL_DBG_OVR   4'hd

// Control register fields
`define RPU_CTRL_PROT_EN  0
`define RPU_CTRL_ALIGN_EN 1
`define RPU_CTRL_DC_EN    2
`define RPU_CTRL_IC_EN    12
`define RPU_CTRL_RESET    32'h0000_0000

// Debug override register
`define RPU_DBG_IMP_EN    0
`define RPU_DBG_RESET     32'h0000_0001

// Region descriptor fields
`define RPU_DESC_BASE_HI  31
`define RPU_DESC_BASE_LO  12
`define RPU_DESC_SIZE_HI  5
`define RPU_DESC_SIZE_LO  1
`define RPU_DESC_EN       0
`define RPU_DESC_MASK     32'hffff_f03f

// Fault status fields
`define RPU_FSR_EXTRA     10
`define RPU_FSR_REG_HI    7
`define RPU_FSR_REG_LO    4

// Fault codes
`define RPU_FC_IMPRECISE  4'h6
`define RPU_FC_ALIGN      4'h1
`define RPU_FC_MISS       4'h0
`define RPU_FC_PERM       4'hd
`define RPU_FC_PRECISE    4'h8
`define RPU_FC_DEBUG      4'h2

`define RPU_NUM_REGIONS   8

`endif

// ===== core/rpu_lookup_if.sv
// Lookup carrier between the register file and the region matcher
`timescale 1ns/1ps
`include "rpu_cfg.svh"

interface rpu_lookup_if;
   import rpu_pkg::*;

   rpu_word_t   addr;
   rpu_word_t   desc [`RPU_NUM_REGIONS];
   logic        hit;
   rpu_region_t num;

   modport lookup (input addr, input desc, output hit, output num);
   modport user   (output addr, output desc, input hit, input num);
endinterface : rpu_lookup_if

// ===== core/rpu_pkg.sv
// Types shared by the region protection unit modules
`include "rpu_cfg.svh"

package rpu_pkg;

   typedef logic [31:0] rpu_word_t;
   typedef logic [2:0]  rpu_region_t;

   typedef enum logic [3:0] {
      RPU_FLT_MISS      = `RPU_FC_MISS,
      RPU_FLT_ALIGN     = `RPU_FC_ALIGN,
      RPU_FLT_DEBUG     = `RPU_FC_DEBUG,
      RPU_FLT_IMPRECISE = `RPU_FC_IMPRECISE,
      RPU_FLT_PRECISE   = `RPU_FC_PRECISE,
      RPU_FLT_PERM      = `RPU_FC_PERM
   } rpu_fault_t;

endpackage : rpu_pkg

// ===== core/rpu_region_match.sv
// Region matcher: finds the highest enabled region holding an address
`timescale 1ns/1ps
`include "rpu_cfg.svh"

module rpu_region_match
   import rpu_pkg::*;
(
   // Lookup request and result
   rpu_lookup_if.lookup lk
);

   // Compare only base bits above the region size
   function automatic logic rpu_hit(input rpu_word_t d, input rpu_word_t a);
      logic       ok;
      logic [4:0] sz;
      ok = d[`RPU_DESC_EN]; // RL4
      sz = d[`RPU_DESC_SIZE_HI:`RPU_DESC_SIZE_LO]; // RL3
      for (int b = `RPU_DESC_BASE_LO; b <= `RPU_DESC_BASE_HI; b++)
      begin
         // Sizes below 4KB still compare every base bit
         if (b > int'(sz) && d[b] != a[b])
         begin
            ok = 1'b0; // RL26
         end
      end
      return ok;
   endfunction : rpu_hit

   always_comb
   begin
      lk.hit = 1'b0;
      lk.num = 3'h0;
      // Ascending scan, so the last match is the highest number
      for (int i = 0; i < `RPU_NUM_REGIONS; i++)
      begin
         if (rpu_hit(lk.desc[i], lk.addr))
         begin
            lk.hit = 1'b1;
            lk.num = 3'(i); // RL13
         end
      end
   end

endmodule : rpu_region_match

// ===== core/rpu_region_protection_unit.sv
// Region protection unit: region checks, attributes and fault recording
`timescale 1ns/1ps
`include "rpu_cfg.svh"

// Operation
// RL1: Protection unit is used only while the select strap is held low.
// RL2: Software aligns each region base to its size; misalignment undefined.
// RL3: Each descriptor has a five-bit size field, 4KB up to 4GB.
// RL4: Descriptor bit 0 enables the region; disabled regions never match.
// RL5: Extended format keeps four-bit data and instruction permissions.
// RL6: Standard format keeps two-bit permission shared by data and fetch; the unit keeps separate data and instruction standard views.
// RL7: Failed permission check gives data abort or prefetch abort.
// RL8: Bufferable bit affects data accesses only, never fetches.
// RL9: Separate data and instruction cachable bits, each for its type.
// RL10: Control bit enables region checking; clear means no checks.
// RL11: Protection off: fetches cachable exactly when instruction cache on.
// RL12: Protection off: data noncachable and nonbufferable always.
// RL13: Highest-numbered matching region supplies the attributes.
// RL14: Address in no enabled region aborts as a region miss.
// RL15: Priority: imprecise, alignment, miss, then following codes.
// RL16: Then permission, precise external, debug lowest; extra bit clear.
// RL17: Imprecise abort records the address of its attached access.
// RL18: Region field invalid for imprecise, alignment and miss faults.
// RL19: Alignment faults only for data, gated, work with protection off.
// RL20: Miss and permission faults apply to data and fetches.
// RL21: Precise aborts always; imprecise only when enable bit set.
// RL22: Each fault writes matching status and address registers.
// RL23: Status bits 7 to 4 hold the faulting region number.
// RL24: Descriptor base in bits 31 to 12, size in 5 to 1.
// RL25: Control bit 0 enables protection, bit 1 alignment checks.
// RL26: Size value N means a region of two to N plus one bytes.
// RL27: Lookup and check finish in the access stage before side effects.
module rpu_region_protection_unit
   import rpu_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // Static configuration strap
   input  wire logic        translation_or_protection_select,
   // Access from the integer unit
   input  wire logic        acc_valid,
   input  wire logic        acc_instr,
   input  wire logic        acc_write,
   input  wire logic        acc_priv,
   input  wire logic [1:0]  acc_size,
   input  wire logic [31:0] modified_virtual_address,
   // External abort and debug events
   input  wire logic        ext_precise_abort,
   input  wire logic        ext_imprecise_abort,
   input  wire logic        debug_hit,
   // Coprocessor register port
   input  wire logic        cp_wr,
   input  wire logic [3:0]  cp_sel,
   input  wire logic [2:0]  cp_idx,
   input  wire logic [31:0] cp_wdata,
   output logic      [31:0] cp_rdata,
   // Access results
   output logic             prot_active,
   output logic             acc_done,
   output logic             data_abort,
   output logic             prefetch_abort,
   output logic             acc_cachable,
   output logic             acc_bufferable
);

   // Permission decode shared by data and fetch paths
   function automatic logic rpu_perm_ok(input logic [3:0] ap,
                                        input logic       priv,
                                        input logic       wr);
      logic ok;
      case (ap)
         4'h1:    ok = priv;
         4'h2:    ok = priv | ~wr;
         4'h3:    ok = 1'b1;
         4'h5:    ok = priv & ~wr;
         4'h6:    ok = ~wr;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction : rpu_perm_ok

   // Misalignment for word and halfword data
   function automatic logic rpu_misaligned(input logic [1:0] size,
                                           input logic [1:0] a);
      logic m;
      case (size)
         2'h1:    m = a[0];
         2'h2:    m = a != 2'h0;
         default: m = 1'b0;
      endcase
      return m;
   endfunction : rpu_misaligned

   // Programmable state
   rpu_word_t   ctrl;
   rpu_word_t   dbg_ovr;
   logic [7:0]  dcache_cfg;
   logic [7:0]  icache_cfg;
   logic [7:0]  buffer_cfg;
   rpu_word_t   data_ap;
   rpu_word_t   instr_ap;
   rpu_word_t   data_fsr;
   rpu_word_t   instr_fsr;
   rpu_word_t   data_fault_addr;
   rpu_word_t   instr_fault_addr;
   rpu_word_t   region_descriptor [`RPU_NUM_REGIONS];

   rpu_word_t   next_ctrl;
   rpu_word_t   next_dbg_ovr;
   logic [7:0]  next_dcache_cfg;
   logic [7:0]  next_icache_cfg;
   logic [7:0]  next_buffer_cfg;
   rpu_word_t   next_data_ap;
   rpu_word_t   next_instr_ap;
   rpu_word_t   next_data_fsr;
   rpu_word_t   next_instr_fsr;
   rpu_word_t   next_data_fault_addr;
   rpu_word_t   next_instr_fault_addr;
   rpu_word_t   next_region_descriptor [`RPU_NUM_REGIONS];
   rpu_word_t   next_cp_rdata;
   logic        next_prot_active;
   logic        next_acc_done;
   logic        next_data_abort;
   logic        next_prefetch_abort;
   logic        next_acc_cachable;
   logic        next_acc_bufferable;

   // Access check terms
   logic        prot_on;
   logic [3:0]  ap;
   logic        f_imp;
   logic        f_align;
   logic        f_miss;
   logic        f_perm;
   logic        fault;
   rpu_fault_t  code;
   logic        extra;
   logic        reg_valid;
   rpu_word_t   fsr_val;

   rpu_lookup_if lk ();

   assign lk.addr = modified_virtual_address;
   assign lk.desc = region_descriptor;

   rpu_region_match u_match
   (
      .lk (lk) // RL26
   );

   // Fault detection and priority, all within the access cycle
   always_comb
   begin
      prot_on = prot_active & ctrl[`RPU_CTRL_PROT_EN]; // RL1 RL10 RL25
      ap = acc_instr ? instr_ap[{lk.num, 2'b00} +: 4]
                     : data_ap[{lk.num, 2'b00} +: 4]; // RL5 RL13
      // Imprecise aborts ride on a data access only
      f_imp = ext_imprecise_abort & ~acc_instr &
              dbg_ovr[`RPU_DBG_IMP_EN]; // RL21
      f_align = ~acc_instr & ctrl[`RPU_CTRL_ALIGN_EN] &
                rpu_misaligned(acc_size,
                   modified_virtual_address[1:0]); // RL19 RL25
      f_miss = prot_on & ~lk.hit; // RL14 RL20
      f_perm = prot_on & lk.hit &
               ~rpu_perm_ok(ap, acc_priv, acc_write); // RL7 RL20
      extra = 1'b0;
      reg_valid = 1'b1;
      if (f_imp)
      begin
         code = RPU_FLT_IMPRECISE; // RL15
         extra = 1'b1;
         reg_valid = 1'b0; // RL18
      end
      else if (f_align)
      begin
         code = RPU_FLT_ALIGN; // RL15
         reg_valid = 1'b0; // RL18
      end
      else if (f_miss)
      begin
         code = RPU_FLT_MISS; // RL15
         reg_valid = 1'b0; // RL18
      end
      else if (f_perm)
      begin
         code = RPU_FLT_PERM; // RL16
      end
      else if (ext_precise_abort)
      begin
         code = RPU_FLT_PRECISE; // RL16 RL21
      end
      else
      begin
         code = RPU_FLT_DEBUG; // RL16
      end
      fault = acc_valid & prot_active &
              (f_imp | f_align | f_miss | f_perm |
               ext_precise_abort | debug_hit); // RL27
      fsr_val = '0;
      fsr_val[`RPU_FSR_EXTRA] = extra;
      fsr_val[`RPU_FSR_REG_HI:`RPU_FSR_REG_LO] =
         reg_valid ? {1'b0, lk.num} : 4'h0; // RL23
      fsr_val[3:0] = code;
   end

   // Register writes, fault capture and results
   always_comb
   begin
      next_ctrl = ctrl;
      next_dbg_ovr = dbg_ovr;
      next_dcache_cfg = dcache_cfg;
      next_icache_cfg = icache_cfg;
      next_buffer_cfg = buffer_cfg;
      next_data_ap = data_ap;
      next_instr_ap = instr_ap;
      next_data_fsr = data_fsr;
      next_instr_fsr = instr_fsr;
      next_data_fault_addr = data_fault_addr;
      next_instr_fault_addr = instr_fault_addr;
      next_region_descriptor = region_descriptor;
      if (cp_wr)
      begin
         case (cp_sel)
            `RPU_SEL_CTRL:    next_ctrl = cp_wdata;
            `RPU_SEL_DBG_OVR: next_dbg_ovr = cp_wdata;
            `RPU_SEL_DCACHE:  next_dcache_cfg = cp_wdata[7:0];
            `RPU_SEL_ICACHE:  next_icache_cfg = cp_wdata[7:0];
            `RPU_SEL_BUFFER:  next_buffer_cfg = cp_wdata[7:0];
            `RPU_SEL_DAP_EXT: next_data_ap = cp_wdata;
            `RPU_SEL_IAP_EXT: next_instr_ap = cp_wdata;
            `RPU_SEL_DAP_STD:
            begin
               for (int i = 0; i < `RPU_NUM_REGIONS; i++)
               begin
                  next_data_ap[i*4 +: 4] = {2'b00, cp_wdata[i*2 +: 2]};
               end
            end
            `RPU_SEL_IAP_STD:
            begin
               for (int i = 0; i < `RPU_NUM_REGIONS; i++)
               begin
                  next_instr_ap[i*4 +: 4] = {2'b00, cp_wdata[i*2 +: 2]};
               end
            end
            `RPU_SEL_DFSR:    next_data_fsr = cp_wdata;
            `RPU_SEL_IFSR:    next_instr_fsr = cp_wdata;
            `RPU_SEL_DFAR:    next_data_fault_addr = cp_wdata;
            `RPU_SEL_IFAR:    next_instr_fault_addr = cp_wdata;
            `RPU_SEL_REGION:
               next_region_descriptor[cp_idx] =
                  cp_wdata & `RPU_DESC_MASK; // RL3 RL4 RL24
            default:          next_ctrl = ctrl;
         endcase
      end
      // A fault in the same cycle as a software write wins
      if (fault && acc_instr)
      begin
         next_instr_fsr = fsr_val; // RL22
         next_instr_fault_addr = modified_virtual_address; // RL22
      end
      else if (fault)
      begin
         next_data_fsr = fsr_val; // RL22
         next_data_fault_addr = modified_virtual_address; // RL17 RL22
      end

      next_prot_active = ~translation_or_protection_select; // RL1
      next_acc_done = acc_valid;
      next_data_abort = fault & ~acc_instr; // RL7
      next_prefetch_abort = fault & acc_instr; // RL7
      // Aborted accesses carry no attributes
      if (fault || !acc_valid || !prot_active)
      begin
         next_acc_cachable = 1'b0;
         next_acc_bufferable = 1'b0;
      end
      else if (!prot_on)
      begin
         next_acc_cachable = acc_instr & ctrl[`RPU_CTRL_IC_EN]; // RL11 RL12
         next_acc_bufferable = 1'b0; // RL12
      end
      else if (acc_instr)
      begin
         next_acc_cachable = ctrl[`RPU_CTRL_IC_EN] &
                             icache_cfg[lk.num]; // RL9
         next_acc_bufferable = 1'b0; // RL8
      end
      else
      begin
         next_acc_cachable = ctrl[`RPU_CTRL_DC_EN] &
                             dcache_cfg[lk.num]; // RL9
         next_acc_bufferable = buffer_cfg[lk.num]; // RL8
      end
   end

   // Read mux, one cycle behind the selector
   always_comb
   begin
      next_cp_rdata = '0;
      case (cp_sel)
         `RPU_SEL_CTRL:    next_cp_rdata = ctrl;
         `RPU_SEL_DBG_OVR: next_cp_rdata = dbg_ovr;
         `RPU_SEL_DCACHE:  next_cp_rdata = {24'h0, dcache_cfg};
         `RPU_SEL_ICACHE:  next_cp_rdata = {24'h0, icache_cfg};
         `RPU_SEL_BUFFER:  next_cp_rdata = {24'h0, buffer_cfg};
         `RPU_SEL_DAP_EXT: next_cp_rdata = data_ap;
         `RPU_SEL_IAP_EXT: next_cp_rdata = instr_ap;
         `RPU_SEL_DAP_STD:
         begin
            for (int i = 0; i < `RPU_NUM_REGIONS; i++)
            begin
               next_cp_rdata[i*2 +: 2] = data_ap[i*4 +: 2]; // RL6
            end
         end
         `RPU_SEL_IAP_STD:
         begin
            for (int i = 0; i < `RPU_NUM_REGIONS; i++)
            begin
               next_cp_rdata[i*2 +: 2] = instr_ap[i*4 +: 2]; // RL6
            end
         end
         `RPU_SEL_DFSR:    next_cp_rdata = data_fsr;
         `RPU_SEL_IFSR:    next_cp_rdata = instr_fsr;
         `RPU_SEL_DFAR:    next_cp_rdata = data_fault_addr;
         `RPU_SEL_IFAR:    next_cp_rdata = instr_fault_addr;
         `RPU_SEL_REGION:  next_cp_rdata = region_descriptor[cp_idx];
         default:          next_cp_rdata = '0;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         ctrl <= `RPU_CTRL_RESET;
         dbg_ovr <= `RPU_DBG_RESET; // RL21
         dcache_cfg <= 8'h00;
         icache_cfg <= 8'h00;
         buffer_cfg <= 8'h00;
         data_ap <= 32'h0000_0000;
         instr_ap <= 32'h0000_0000;
         data_fsr <= 32'h0000_0000;
         instr_fsr <= 32'h0000_0000;
         data_fault_addr <= 32'h0000_0000;
         instr_fault_addr <= 32'h0000_0000;
         for (int i = 0; i < `RPU_NUM_REGIONS; i++)
         begin
            region_descriptor[i] <= 32'h0000_0000;
         end
         cp_rdata <= 32'h0000_0000;
         prot_active <= 1'b0;
         acc_done <= 1'b0;
         data_abort <= 1'b0;
         prefetch_abort <= 1'b0;
         acc_cachable <= 1'b0;
         acc_bufferable <= 1'b0;
      end
      else
      begin
         ctrl <= next_ctrl;
         dbg_ovr <= next_dbg_ovr;
         dcache_cfg <= next_dcache_cfg;
         icache_cfg <= next_icache_cfg;
         buffer_cfg <= next_buffer_cfg;
         data_ap <= next_data_ap;
         instr_ap <= next_instr_ap;
         data_fsr <= next_data_fsr;
         instr_fsr <= next_instr_fsr;
         data_fault_addr <= next_data_fault_addr;
         instr_fault_addr <= next_instr_fault_addr;
         region_descriptor <= next_region_descriptor;
         cp_rdata <= next_cp_rdata;
         prot_active <= next_prot_active;
         acc_done <= next_acc_done;
         data_abort <= next_data_abort;
         prefetch_abort <= next_prefetch_abort;
         acc_cachable <= next_acc_cachable;
         acc_bufferable <= next_acc_bufferable;
      end
   end

endmodule : rpu_region_protection_unit

// ===== tb/rpu_assertions.sv
// Port-level temporal checks for the region protection unit
`timescale 1ns/1ps

module rpu_assertions
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Strap and access
   input wire logic translation_or_protection_select,
   input wire logic acc_valid,
   input wire logic acc_instr,
   input wire logic ext_precise_abort,
   input wire logic debug_hit,
   // Results
   input wire logic prot_active,
   input wire logic acc_done,
   input wire logic data_abort,
   input wire logic prefetch_abort,
   input wire logic acc_cachable,
   input wire logic acc_bufferable
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   // Access that the unit is allowed to check
   sequence s_chk;
      acc_valid && prot_active;
   endsequence
   // Some abort in the fixed result cycle
   sequence s_abort;
      ##1 (data_abort || prefetch_abort);
   endsequence

   property p_done;
      acc_valid |=> acc_done;
   endproperty
   a_done: assert property (p_done) else $error("no done");
   property p_idle;
      !acc_valid |=> !acc_done && !data_abort && !prefetch_abort;
   endproperty
   a_idle: assert property (p_idle) else $error("stray result");
   property p_dabort;
      data_abort |-> $past(acc_valid) && !$past(acc_instr);
   endproperty
   a_dabort: assert property (p_dabort) else $error("bad dabort");
   property p_pabort;
      prefetch_abort |-> $past(acc_valid) && $past(acc_instr);
   endproperty
   a_pabort: assert property (p_pabort) else $error("bad pabort");
   property p_nobuf;
      acc_valid && acc_instr |=> !acc_bufferable;
   endproperty
   a_nobuf: assert property (p_nobuf) else $error("fetch buffered");
   property p_attr;
      data_abort || prefetch_abort |-> !acc_cachable && !acc_bufferable;
   endproperty
   a_attr: assert property (p_attr) else $error("abort attrs");
   property p_strap;
      !prot_active && acc_valid |=> !data_abort && !prefetch_abort
         && !acc_cachable && !acc_bufferable;
   endproperty
   a_strap: assert property (p_strap) else $error("unit not idle");
   property p_act;
      !translation_or_protection_select |=> prot_active;
   endproperty
   a_act: assert property (p_act) else $error("unit not active");
   property p_precise;
      s_chk ##0 ext_precise_abort |-> s_abort;
   endproperty
   a_precise: assert property (p_precise) else $error("lost abort");
   property p_debug;
      s_chk ##0 debug_hit |-> s_abort;
   endproperty
   a_debug: assert property (p_debug) else $error("lost debug");
endmodule : rpu_assertions

// ===== tb/rpu_core_model.sv
// Integer unit model issuing fetches and data accesses
`timescale 1ns/1ps

module rpu_core_model
(
   // Clock
   input wire logic mclk,
   // Access to the unit
   output logic        acc_valid,
   output logic        acc_instr,
   output logic        acc_write,
   output logic        acc_priv,
   output logic [1:0]  acc_size,
   output logic [31:0] modified_virtual_address,
   output logic        ext_precise_abort,
   output logic        ext_imprecise_abort,
   output logic        debug_hit
);
   initial
   begin
      acc_valid = 1'b0;
      {acc_instr, acc_write, acc_priv, acc_size} = 5'h00;
      {ext_precise_abort, ext_imprecise_abort, debug_hit} = 3'h0;
      modified_virtual_address = 32'h0;
   end

   // f = instr, write, priv, size, precise, imprecise, debug
   task automatic issue(input logic [7:0] f, input logic [31:0] a);
      @(negedge mclk);
      acc_valid = 1'b1;
      {acc_instr, acc_write, acc_priv, acc_size} = f[7:3];
      {ext_precise_abort, ext_imprecise_abort, debug_hit} = f[2:0];
      modified_virtual_address = a;
      @(negedge mclk);
      // Released qualifiers flip so stale values never look valid
      acc_valid = 1'b0;
      {acc_instr, acc_write, acc_priv, acc_size} = ~f[7:3];
      {ext_precise_abort, ext_imprecise_abort, debug_hit} = 3'h0;
      modified_virtual_address = ~a;
   endtask : issue
endmodule : rpu_core_model

// ===== tb/tb.sv
// Self-checking bench for the region protection unit
`timescale 1ns/1ps
`include "rpu_cfg.svh"

module tb;
   logic        mclk, rst, strap, cp_wr;
   logic [3:0]  cp_sel;
   logic [2:0]  cp_idx;
   logic [31:0] cp_wdata, cp_rdata, seed, a;
   logic        acc_valid, acc_instr, acc_write, acc_priv;
   logic [1:0]  acc_size;
   logic [31:0] modified_virtual_address;
   logic        ext_precise_abort, ext_imprecise_abort, debug_hit;
   logic        prot_active, acc_done, data_abort, prefetch_abort;
   logic        acc_cachable, acc_bufferable;
   logic [3:0]  q [$];
   int          n_fail = 0;
   int          samples_checked = 0;

   rpu_core_model core (
      .mclk(mclk), .acc_valid(acc_valid), .acc_instr(acc_instr),
      .acc_write(acc_write), .acc_priv(acc_priv), .acc_size(acc_size),
      .modified_virtual_address(modified_virtual_address),
      .ext_precise_abort(ext_precise_abort),
      .ext_imprecise_abort(ext_imprecise_abort), .debug_hit(debug_hit));

   rpu_region_protection_unit dut (
      .mclk(mclk), .rst(rst), .translation_or_protection_select(strap),
      .acc_valid(acc_valid), .acc_instr(acc_instr),
      .acc_write(acc_write), .acc_priv(acc_priv), .acc_size(acc_size),
      .modified_virtual_address(modified_virtual_address),
      .ext_precise_abort(ext_precise_abort),
      .ext_imprecise_abort(ext_imprecise_abort), .debug_hit(debug_hit),
      .cp_wr(cp_wr), .cp_sel(cp_sel), .cp_idx(cp_idx),
      .cp_wdata(cp_wdata), .cp_rdata(cp_rdata),
      .prot_active(prot_active), .acc_done(acc_done),
      .data_abort(data_abort), .prefetch_abort(prefetch_abort),
      .acc_cachable(acc_cachable), .acc_bufferable(acc_bufferable));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic end_sim;
      $display("checked %0d failed %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [3:0] s, input logic [2:0] i,
                     input logic [31:0] d);
      @(negedge mclk);
      cp_wr = 1'b1;
      cp_sel = s;
      cp_idx = i;
      cp_wdata = d;
      @(negedge mclk);
      cp_wr = 1'b0;
      cp_wdata = ~d;
   endtask : wr

   task automatic rd(input logic [3:0] s, input logic [2:0] i,
                     input logic [31:0] e);
      @(negedge mclk);
      cp_sel = s;
      cp_idx = i;
      @(negedge mclk);
      chk(cp_rdata, e);
   endtask : rd

   // Expectation {data abort, prefetch abort, cachable, bufferable}
   task automatic acc(input logic [7:0] f, input logic [31:0] ad,
                      input logic [3:0] e);
      q.push_back(e);
      core.issue(f, ad);
   endtask : acc

   // Result watcher: oldest note against each completed access
   always @(negedge mclk)
      if (acc_done === 1'b1)
      begin
         if (q.size() == 0)
            chk(32'h1, 32'h0);
         else
            chk({28'h0, data_abort, prefetch_abort, acc_cachable,
                 acc_bufferable}, {28'h0, q.pop_front()});
      end

   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // Generous bound; the sequence needs under two hundred cycles
   initial
   begin
      repeat (5000) @(posedge mclk);
      n_fail++;
      end_sim();
   end

   initial
   begin
      rst = 1'b1;
      strap = 1'b0;
      cp_wr = 1'b0;
      cp_sel = 4'h0;
      cp_idx = 3'h0;
      cp_wdata = 32'h0;
      seed = 32'h6b60;
      repeat (20) @(posedge mclk);
      @(negedge mclk);
      rst = 1'b0;
      rd(`RPU_SEL_CTRL, 3'h0, `RPU_CTRL_RESET);
      rd(`RPU_SEL_DBG_OVR, 3'h0, `RPU_DBG_RESET);
      rd(4'he, 3'h0, 32'h0);
      for (int i = 0; i < 8; i++)
      begin
         seed = lfsr(seed);
         wr(`RPU_SEL_REGION, i[2:0], seed);
         rd(`RPU_SEL_REGION, i[2:0], seed & `RPU_DESC_MASK);
         wr(`RPU_SEL_REGION, i[2:0], 32'h0);
      end
      wr(`RPU_SEL_DAP_STD, 3'h0, 32'h27);
      rd(`RPU_SEL_DAP_EXT, 3'h0, 32'h213);
      rd(`RPU_SEL_DAP_STD, 3'h0, 32'h27);
      wr(`RPU_SEL_IAP_EXT, 3'h0, 32'h313);
      rd(`RPU_SEL_IAP_EXT, 3'h0, 32'h313);
      rd(`RPU_SEL_IAP_STD, 3'h0, 32'h37);
      // Protection off, caches on, random miss address
      seed = lfsr(seed);
      a = {seed[31:2], 2'b00};
      wr(`RPU_SEL_CTRL, 3'h0, 32'h1004);
      acc(8'hb0, a, 4'h2);
      acc(8'h30, a, 4'h0);
      wr(`RPU_SEL_CTRL, 3'h0, 32'h0006);
      acc(8'hb0, a, 4'h0);
      acc(8'h90, a | 32'h1, 4'h0);
      acc(8'h10, a | 32'h1, 4'h8);
      rd(`RPU_SEL_DFSR, 3'h0, 32'h1);
      rd(`RPU_SEL_DFAR, 3'h0, a | 32'h1);
      // Background, 16KB and 4KB overlapping regions, bases aligned
      wr(`RPU_SEL_REGION, 3'h0, 32'h3f);
      wr(`RPU_SEL_REGION, 3'h1, 32'h1b);
      wr(`RPU_SEL_REGION, 3'h2, 32'h3017);
      wr(`RPU_SEL_DAP_EXT, 3'h0, 32'h613);
      wr(`RPU_SEL_DCACHE, 3'h0, 32'h4);
      wr(`RPU_SEL_ICACHE, 3'h0, 32'h1);
      wr(`RPU_SEL_BUFFER, 3'h0, 32'h4);
      wr(`RPU_SEL_CTRL, 3'h0, 32'h1007);
      acc(8'h10, 32'h3010, 4'h3);
      acc(8'h28, 32'h3012, 4'h3);
      acc(8'h50, 32'h3010, 4'h8);
      rd(`RPU_SEL_DFSR, 3'h0, 32'h2d);
      acc(8'h10, 32'h1000, 4'h8);
      rd(`RPU_SEL_DFSR, 3'h0, 32'h1d);
      acc(8'hb0, 32'h3010, 4'h0);
      acc(8'hb0, 32'h8000, 4'h2);
      acc(8'h30, 32'h8000, 4'h0);
      acc(8'h90, 32'h1000, 4'h4);
      rd(`RPU_SEL_IFSR, 3'h0, 32'h1d);
      rd(`RPU_SEL_IFAR, 3'h0, 32'h1000);
      // Background off: random high address misses
      wr(`RPU_SEL_REGION, 3'h0, 32'h0);
      seed = lfsr(seed);
      a = {1'b1, seed[30:2], 2'b00};
      acc(8'hb0, a, 4'h4);
      rd(`RPU_SEL_IFSR, 3'h0, 32'h0);
      rd(`RPU_SEL_IFAR, 3'h0, a);
      // Coinciding faults
      acc(8'h15, 32'h1002, 4'h8);
      rd(`RPU_SEL_DFSR, 3'h0, 32'h1);
      acc(8'h17, 32'h1002, 4'h8);
      rd(`RPU_SEL_DFSR, 3'h0, 32'h406);
      rd(`RPU_SEL_DFAR, 3'h0, 32'h1002);
      acc(8'h34, 32'h8000_0000, 4'h8);
      rd(`RPU_SEL_DFSR, 3'h0, 32'h0);
      acc(8'h35, 32'h3010, 4'h8);
      rd(`RPU_SEL_DFSR, 3'h0, 32'h28);
      acc(8'h31, 32'h3010, 4'h8);
      rd(`RPU_SEL_DFSR, 3'h0, 32'h22);
      wr(`RPU_SEL_DBG_OVR, 3'h0, 32'h0);
      acc(8'h32, 32'h3010, 4'h3);
      rd(`RPU_SEL_DBG_OVR, 3'h0, 32'h0);
      // Translation selected: nothing is checked
      strap = 1'b1;
      acc(8'h30, 32'h8000_0000, 4'h0);
      chk({31'h0, prot_active}, 32'h0);
      strap = 1'b0;
      repeat (3) @(negedge mclk);
      chk(q.size(), 32'h0);
      end_sim();
   end
endmodule : tb

bind rpu_region_protection_unit rpu_assertions u_chk (
   .mclk(mclk), .rst(rst),
   .translation_or_protection_select(translation_or_protection_select),
   .acc_valid(acc_valid), .acc_instr(acc_instr),
   .ext_precise_abort(ext_precise_abort), .debug_hit(debug_hit),
   .prot_active(prot_active), .acc_done(acc_done),
   .data_abort(data_abort), .prefetch_abort(prefetch_abort),
   .acc_cachable(acc_cachable), .acc_bufferable(acc_bufferable));
